// File: hw/rgbo_pkg.sv
package rgbo_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] RGBO_ADDR_CONTROL       = 8'h00;  // Control register
  localparam logic [7:0] RGBO_ADDR_COLOUR_BRIGHT = 8'h01;  // Colour and brightness, stored only
  localparam logic [7:0] RGBO_ADDR_CURRENT       = 8'h02;  // colour_current_levels
  localparam logic [7:0] RGBO_ADDR_GPIO_CONTROL  = 8'h06;  // Pin function and gate selects

  // Control register fields
  localparam int RGBO_CTL_INTERNAL_PWM_BIT = 7;  // internal_pwm_enable
  localparam int RGBO_CTL_BLOCK_EN_BIT     = 6;  // colour_block_enable
  localparam int RGBO_CTL_MODE_BIT         = 5;  // output_mode_select, 1 = switch
  localparam int RGBO_CTL_RED_SW_BIT       = 3;  // red_switch_enable
  localparam int RGBO_CTL_GREEN_SW_BIT     = 2;  // green_switch_enable
  localparam int RGBO_CTL_BLUE_SW_BIT      = 1;  // blue_switch_enable
  localparam logic [7:0] RGBO_CTL_WRITE_MASK = 8'hee;  // Bits 4 and 0 read as zero

  // Current level register fields
  localparam int RGBO_CUR_RED_LSB   = 4;  // red_current_level
  localparam int RGBO_CUR_GREEN_LSB = 2;  // green_current_level
  localparam int RGBO_CUR_BLUE_LSB  = 0;  // blue_current_level
  localparam logic [7:0] RGBO_CUR_WRITE_MASK = 8'h3f;  // Bits 7:6 read as zero

  // GPIO control register fields
  localparam int RGBO_GPIO_PIN_PWM_BIT   = 4;  // Pin used as external PWM input
  localparam int RGBO_GPIO_RED_GATE_BIT  = 3;  // red_external_gate
  localparam int RGBO_GPIO_GREEN_GATE_BIT = 2; // green_external_gate
  localparam int RGBO_GPIO_BLUE_GATE_BIT = 1;  // blue_external_gate
  localparam logic [7:0] RGBO_GPIO_WRITE_MASK = 8'h1e;  // Other bits read as zero

  // Reset values
  localparam logic [7:0] RGBO_CTL_RESET    = 8'h20;  // Switch mode after reset
  localparam logic [7:0] RGBO_BRIGHT_RESET = 8'h00;
  localparam logic [7:0] RGBO_CUR_RESET    = 8'h00;
  localparam logic [7:0] RGBO_GPIO_RESET   = 8'h00;
  localparam logic [7:0] RGBO_READ_ZERO    = 8'h00;  // Answer for unmapped offsets

  // Channel indices and count
  localparam int RGBO_CHANNELS  = 3;
  localparam int RGBO_CH_RED    = 2;
  localparam int RGBO_CH_GREEN  = 1;
  localparam int RGBO_CH_BLUE   = 0;

  // Two-bit level to quarters of full current: 00 -> 1 .. 11 -> 4
  localparam logic [2:0] RGBO_QUARTER_ONE = 3'h1;

endpackage : rgbo_pkg

// File: hw/rgbo_channel.sv
// One colour output: combines switch, gate, pin and internal waveform
module rgbo_channel
  import rgbo_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       block_enable,
  input  wire logic       internal_pwm,
  input  wire logic       switch_enable,
  input  wire logic       external_gate,
  input  wire logic       pin_pwm_active,
  input  wire logic       pin_level,
  input  wire logic       internal_wave,
  input  wire logic [1:0] level,
  output logic            drive,
  output logic      [2:0] quarters
);

  logic       drive_d;     // Next on/off state
  logic       drive_q;     // Registered on/off state
  logic [2:0] quarters_d;  // Next current scale
  logic [2:0] quarters_q;  // Registered current scale
  logic       source;      // Switch, optionally modulated internally

  // Output decision
  always_comb begin
    // Contents of the colour and brightness register never enter here
    if (internal_pwm) begin
      source = switch_enable & internal_wave;
    end else begin
      source = switch_enable;
    end
    if (!block_enable) begin
      drive_d = 1'b0;
    end else if (pin_pwm_active && external_gate) begin
      // Pin is active high; off while low, passes source while high
      drive_d = source & pin_level;
    end else begin
      // Ungated outputs ignore the pin entirely
      drive_d = source;
    end
    quarters_d = {1'b0, level} + RGBO_QUARTER_ONE;
  end

  // Registered outputs keep glitches from reaching the pads
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      drive_q    <= 1'b0;
      quarters_q <= RGBO_QUARTER_ONE;
    end else begin
      drive_q    <= drive_d;
      quarters_q <= quarters_d;
    end
  end

  assign drive    = drive_q;
  assign quarters = quarters_q;

endmodule : rgbo_channel

// File: hw/rgbo_output_control.sv
module rgbo_output_control
  import rgbo_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_address,
  input  wire logic [7:0] reg_write_data,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_read_data,
  input  wire logic       pwm_pin,
  input  wire logic [2:0] internal_pwm_wave,
  output logic            red_output,
  output logic            green_output,
  output logic            blue_output,
  output logic            output_mode_select,
  output logic      [2:0] red_current_scale,
  output logic      [2:0] green_current_scale,
  output logic      [2:0] blue_current_scale
);

  // Register state
  logic [7:0] control_q;      // Control register
  logic [7:0] control_d;
  logic [7:0] bright_q;       // Colour and brightness, kept for read-back
  logic [7:0] bright_d;
  logic [7:0] current_q;      // colour_current_levels
  logic [7:0] current_d;
  logic [7:0] gpio_q;         // GPIO control register
  logic [7:0] gpio_d;
  logic [7:0] read_data_q;    // Registered read answer
  logic [7:0] read_data_d;

  // Pin synchroniser, first stage read only by the second
  logic       pin_meta_q;
  logic       pin_sync_q;

  // Decoded fields
  logic       internal_pwm_enable;
  logic       colour_block_enable;
  logic       red_switch_enable;
  logic       green_switch_enable;
  logic       blue_switch_enable;
  logic       red_external_gate;
  logic       green_external_gate;
  logic       blue_external_gate;
  logic [1:0] red_current_level;
  logic [1:0] green_current_level;
  logic [1:0] blue_current_level;
  logic       pin_pwm_active;

  // Per-channel vectors, indexed by the channel constants
  logic [2:0] switch_vec;
  logic [2:0] gate_vec;
  logic [5:0] level_vec;
  logic [2:0] drive_vec;
  logic [8:0] quarters_vec;

  // Field decode
  assign internal_pwm_enable = control_q[RGBO_CTL_INTERNAL_PWM_BIT];
  assign colour_block_enable = control_q[RGBO_CTL_BLOCK_EN_BIT];
  assign output_mode_select  = control_q[RGBO_CTL_MODE_BIT];
  assign red_switch_enable   = control_q[RGBO_CTL_RED_SW_BIT];
  assign green_switch_enable = control_q[RGBO_CTL_GREEN_SW_BIT];
  assign blue_switch_enable  = control_q[RGBO_CTL_BLUE_SW_BIT];

  assign red_external_gate   = gpio_q[RGBO_GPIO_RED_GATE_BIT];
  assign green_external_gate = gpio_q[RGBO_GPIO_GREEN_GATE_BIT];
  assign blue_external_gate  = gpio_q[RGBO_GPIO_BLUE_GATE_BIT];

  assign red_current_level   = current_q[RGBO_CUR_RED_LSB +: 2];
  assign green_current_level = current_q[RGBO_CUR_GREEN_LSB +: 2];
  assign blue_current_level  = current_q[RGBO_CUR_BLUE_LSB +: 2];

  // Pin only acts as PWM input with the block enabled
  assign pin_pwm_active = gpio_q[RGBO_GPIO_PIN_PWM_BIT] & colour_block_enable;

  // Gather per-channel controls
  assign switch_vec[RGBO_CH_RED]   = red_switch_enable;
  assign switch_vec[RGBO_CH_GREEN] = green_switch_enable;
  assign switch_vec[RGBO_CH_BLUE]  = blue_switch_enable;
  assign gate_vec[RGBO_CH_RED]     = red_external_gate;
  assign gate_vec[RGBO_CH_GREEN]   = green_external_gate;
  assign gate_vec[RGBO_CH_BLUE]    = blue_external_gate;
  assign level_vec[RGBO_CH_RED*2 +: 2]   = red_current_level;
  assign level_vec[RGBO_CH_GREEN*2 +: 2] = green_current_level;
  assign level_vec[RGBO_CH_BLUE*2 +: 2]  = blue_current_level;

  // Register writes; unmapped offsets are dropped without effect
  always_comb begin
    control_d = control_q;
    bright_d  = bright_q;
    current_d = current_q;
    gpio_d    = gpio_q;
    if (reg_write) begin
      case (reg_address)
        RGBO_ADDR_CONTROL: begin
          control_d = reg_write_data & RGBO_CTL_WRITE_MASK;
        end
        RGBO_ADDR_COLOUR_BRIGHT: begin
          // Stored for the internal engine; no effect on direct control
          bright_d = reg_write_data;
        end
        RGBO_ADDR_CURRENT: begin
          current_d = reg_write_data & RGBO_CUR_WRITE_MASK;
        end
        RGBO_ADDR_GPIO_CONTROL: begin
          gpio_d = reg_write_data & RGBO_GPIO_WRITE_MASK;
        end
        default: begin
          // Unmapped write ignored
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control_q <= RGBO_CTL_RESET;
      bright_q  <= RGBO_BRIGHT_RESET;
      current_q <= RGBO_CUR_RESET;
      gpio_q    <= RGBO_GPIO_RESET;
    end else begin
      control_q <= control_d;
      bright_q  <= bright_d;
      current_q <= current_d;
      gpio_q    <= gpio_d;
    end
  end

  // Read mux; answer holds until the next read strobe
  always_comb begin
    read_data_d = read_data_q;
    if (reg_read) begin
      case (reg_address)
        RGBO_ADDR_CONTROL: begin
          read_data_d = control_q;
        end
        RGBO_ADDR_COLOUR_BRIGHT: begin
          read_data_d = bright_q;
        end
        RGBO_ADDR_CURRENT: begin
          read_data_d = current_q;
        end
        RGBO_ADDR_GPIO_CONTROL: begin
          read_data_d = gpio_q;
        end
        default: begin
          read_data_d = RGBO_READ_ZERO;  // Unmapped reads as zero
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_data_q <= RGBO_READ_ZERO;
    end else begin
      read_data_q <= read_data_d;
    end
  end

  assign reg_read_data = read_data_q;

  // Pin is asynchronous to the clock; two flops before any use.
  // Costs two cycles of latency on flash edges, far below pin pulse widths.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= pwm_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // One gating slice per colour output
  for (genvar ch = 0; ch < RGBO_CHANNELS; ch++) begin : g_channel
    rgbo_channel u_channel (
      .clock          (clock),
      .reset_n        (reset_n),
      .block_enable   (colour_block_enable),
      .internal_pwm   (internal_pwm_enable),
      .switch_enable  (switch_vec[ch]),
      .external_gate  (gate_vec[ch]),
      .pin_pwm_active (pin_pwm_active),
      .pin_level      (pin_sync_q),
      .internal_wave  (internal_pwm_wave[ch]),
      .level          (level_vec[ch*2 +: 2]),
      .drive          (drive_vec[ch]),
      .quarters       (quarters_vec[ch*3 +: 3])
    );
  end

  // Pin-level outputs
  assign red_output          = drive_vec[RGBO_CH_RED];
  assign green_output        = drive_vec[RGBO_CH_GREEN];
  assign blue_output         = drive_vec[RGBO_CH_BLUE];
  // Scale only matters to the analog sink in current mode
  assign red_current_scale   = quarters_vec[RGBO_CH_RED*3 +: 3];
  assign green_current_scale = quarters_vec[RGBO_CH_GREEN*3 +: 3];
  assign blue_current_scale  = quarters_vec[RGBO_CH_BLUE*3 +: 3];

endmodule : rgbo_output_control

// File: bench/rgbo_output_control_monitor.sv
// Port-level checker for the colour output block
module rgbo_output_control_monitor (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [7:0] reg_address,
  input wire logic [7:0] reg_write_data,
  input wire logic       reg_write,
  input wire logic       pwm_pin,
  input wire logic       red_output,
  input wire logic       green_output,
  input wire logic       blue_output,
  input wire logic       output_mode_select,
  input wire logic [2:0] red_current_scale,
  input wire logic [2:0] blue_current_scale
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] ctl_q;  // Shadow of control
  logic [7:0] gpio_q; // Shadow of pin function
  wire logic ctl_wr = reg_write && reg_address == 8'h00; // Control write
  wire logic cur_wr = reg_write && reg_address == 8'h02; // Level write
  // Pin needs 3 edges to land, so gated waits are 5
  wire logic red_gated = ctl_q[6] & ctl_q[3] & gpio_q[4] & gpio_q[3];
  // Shadows follow host writes only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 8'h20;
      gpio_q <= 8'h00;
    end else if (ctl_wr) begin
      ctl_q <= reg_write_data;
    end else if (reg_write && reg_address == 8'h06) begin
      gpio_q <= reg_write_data;
    end
  end
  property p_off; ctl_wr && !reg_write_data[6] |-> ##2 !(red_output | green_output | blue_output); endproperty
  a_off: assert property (p_off) else $error("lit while disabled");
  property p_mode; ctl_wr |=> output_mode_select == $past(reg_write_data[5]); endproperty
  a_mode: assert property (p_mode) else $error("mode not followed");
  property p_red_sw; ctl_wr && reg_write_data[7:6] == 2'b01 && reg_write_data[3] && !gpio_q[4] |-> ##2 red_output;
  endproperty
  a_red_sw: assert property (p_red_sw) else $error("red switch ignored");
  property p_red_lvl; cur_wr |-> ##2 red_current_scale == $past(reg_write_data[5:4], 2) + 3'h1; endproperty
  a_red_lvl: assert property (p_red_lvl) else $error("red scale wrong");
  property p_blue_lvl; cur_wr |-> ##2 blue_current_scale == $past(reg_write_data[1:0], 2) + 3'h1; endproperty
  a_blue_lvl: assert property (p_blue_lvl) else $error("blue scale wrong");
  property p_gate_hi; (red_gated && !ctl_q[7] && pwm_pin)[*5] |-> red_output; endproperty
  a_gate_hi: assert property (p_gate_hi) else $error("gated red off");
  property p_gate_lo; (red_gated && !ctl_q[7] && !pwm_pin)[*5] |-> !red_output; endproperty
  a_gate_lo: assert property (p_gate_lo) else $error("gated red on");
  property p_int_gate; (red_gated && ctl_q[7] && !pwm_pin)[*5] |-> !red_output; endproperty
  a_int_gate: assert property (p_int_gate) else $error("wave passed pin low");
  property p_ungated; (ctl_q[7:6] == 2'b01 && ctl_q[2] && gpio_q[4] && !gpio_q[2])[*3] |-> green_output; endproperty
  a_ungated: assert property (p_ungated) else $error("ungated green off");
endmodule : rgbo_output_control_monitor

// File: bench/rgbo_led_load.sv
// LED on one output; reports sink current in quarters
module rgbo_led_load (
  input  wire logic       lit,
  input  wire logic       switch_mode,
  input  wire logic [2:0] scale,
  output logic      [2:0] current
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ballast resistor sets switch current, shown as full
  assign current = !lit ? 3'h0 : (switch_mode ? 3'h4 : scale);
endmodule : rgbo_led_load

// File: bench/tb.sv
// Drives register port and pin, checks outputs
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 0, reset_n = 0, wr = 0, rd = 0, pin = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] wave = 3'h0, rs, gs, bs, r_i;
  logic       r_o, g_o, b_o, mode;
  int         mismatches = 0;
  int         num_checks = 0;
  // 100 MHz clock
  always #5 clock = ~clock;
  rgbo_output_control i_dut (.clock, .reset_n, .reg_address(addr), .reg_write_data(wdata), .reg_write(wr),
    .reg_read(rd), .reg_read_data(rdata), .pwm_pin(pin), .internal_pwm_wave(wave), .red_output(r_o),
    .green_output(g_o), .blue_output(b_o), .output_mode_select(mode), .red_current_scale(rs),
    .green_current_scale(gs), .blue_current_scale(bs));
  rgbo_led_load i_red (.lit(r_o), .switch_mode(mode), .scale(rs), .current(r_i));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    if (seen !== exp) mismatches++;
  endtask : check
  // Counts, verdict, stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // Write strobe with pin and wave; waits out the 3-edge pin path
  task automatic step(input logic [7:0] a, input logic [7:0] d, input logic [3:0] pw, input logic [2:0] e);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    pin <= pw[3];
    wave <= pw[2:0];
    @(posedge clock);
    wr <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    check({5'h0, r_o, g_o, b_o}, {5'h0, e});
  endtask : step
  // Read strobe; data registered
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock) #1;
    check(rdata, exp);
  endtask : rd_reg
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    check({7'h0, mode}, 8'h01);
    rd_reg(8'h00, 8'h20);
    step(8'h00, 8'h4a, 4'h0, 3'h5);
    step(8'h01, 8'hff, 4'h0, 3'h5);
    rd_reg(8'h01, 8'hff);
    step(8'h00, 8'h4e, 4'h0, 3'h7);
    check({7'h0, mode}, 8'h00);
    step(8'h00, 8'hff, 4'h0, 3'h0);
    rd_reg(8'h00, 8'hee);
    step(8'h00, 8'h0e, 4'h0, 3'h0);
    // Every level code on each channel
    for (int k = 0; k < 4; k++) begin
      step(8'h02, {2'h0, 2'(k), 2'(k + 1), 2'(k + 2)}, 4'h0, 3'h0);
      check({5'h0, rs}, 8'(k + 1));
      check({5'h0, gs}, 8'((k + 1) % 4 + 1));
      check({5'h0, bs}, 8'((k + 2) % 4 + 1));
    end
    step(8'h02, 8'hff, 4'h0, 3'h0);
    rd_reg(8'h02, 8'h3f);
    // Pin flash: pin select and gates first
    step(8'h06, 8'h1a, 4'h0, 3'h0);
    rd_reg(8'h06, 8'h1a);
    step(8'h00, 8'h4e, 4'h0, 3'h2);
    step(8'h01, 8'h00, 4'h8, 3'h7);
    check({5'h0, r_i}, 8'h04);
    step(8'h00, 8'hce, 4'hb, 3'h3);
    step(8'h01, 8'h00, 4'h7, 3'h2);
    step(8'h06, 8'h0a, 4'h7, 3'h7);
    // Level flash: low pre-flash, full flash, switches off
    step(8'h06, 8'h00, 4'h0, 3'h0);
    step(8'h00, 8'h40, 4'h0, 3'h0);
    step(8'h02, 8'h00, 4'h0, 3'h0);
    step(8'h00, 8'h4e, 4'h0, 3'h7);
    check({5'h0, r_i}, 8'h01);
    step(8'h02, 8'h3f, 4'h0, 3'h7);
    check({5'h0, r_i}, 8'h04);
    step(8'h00, 8'h40, 4'h0, 3'h0);
    conclude();
  end
  // Hang guard, far past the roughly 180 cycles used
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule : tb
bind rgbo_output_control rgbo_output_control_monitor i_mon (.clock, .reset_n, .reg_address, .reg_write_data,
  .reg_write, .pwm_pin, .red_output, .green_output, .blue_output, .output_mode_select, .red_current_scale,
  .blue_current_scale);
